// >>> rtl/status_pkg.sv
// Constants for the standard event status reporting block
package status_pkg;
    // Standard event latch bit positions
    localparam int SEL_PON_BIT = 7;
    localparam int SEL_CME_BIT = 5;
    localparam int SEL_EXE_BIT = 4;
    localparam int SEL_DDE_BIT = 3;
    localparam int SEL_QYE_BIT = 2;
    localparam int SEL_OPC_BIT = 0;
    localparam logic [7:0] SEL_USED_MASK = 8'hBD;
    // Status byte bit positions
    localparam int STB_OPER_BIT = 7;
    localparam int STB_MSS_BIT = 6;
    localparam int STB_ESB_BIT = 5;
    localparam int STB_MAV_BIT = 4;
    localparam int STB_QUES_BIT = 3;
    localparam int STB_ERRQ_BIT = 2;
    // Reset values
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] SEL_RESET = 8'h80;
    // Reply of the completion query
    localparam logic [7:0] OPC_REPLY_CHAR = 8'h31;
    // Command codes from the message parser
    localparam logic [3:0] CMD_NONE = 4'h0;
    localparam logic [3:0] CMD_CLS = 4'h1;
    localparam logic [3:0] CMD_ESE = 4'h2;
    localparam logic [3:0] CMD_ESE_Q = 4'h3;
    localparam logic [3:0] CMD_ESR_Q = 4'h4;
    localparam logic [3:0] CMD_OPC = 4'h5;
    localparam logic [3:0] CMD_OPC_Q = 4'h6;
    localparam logic [3:0] CMD_IDN_Q = 4'h7;
    localparam logic [3:0] CMD_SRE = 4'h8;
    localparam logic [3:0] CMD_SRE_Q = 4'h9;
    localparam logic [3:0] CMD_STB_Q = 4'hA;
    localparam logic [3:0] CMD_POLL = 4'hB;
    localparam logic [3:0] CMD_OTHER = 4'hC;
    // Identification field selectors
    localparam logic [2:0] IDN_MAKER = 3'h0;
    localparam logic [2:0] IDN_MODEL = 3'h1;
    localparam logic [2:0] IDN_CALDATE = 3'h2;
    localparam logic [2:0] IDN_SERIAL = 3'h3;
    localparam logic [2:0] IDN_FIRMWARE = 3'h4;
    localparam logic [2:0] IDN_DONE = 3'h5;
    localparam int CALDATE_MAX_CHARS = 10;
endpackage

// >>> rtl/completion_tracker.sv
// Pending-operation tracker for the completion command
`timescale 1ns/100ps
`default_nettype none
module completion_tracker (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic arm_i,
    input wire logic clear_i,
    input wire logic busy_i,
    output logic armed_o,
    output logic done_o
);
    logic armed_q;
    logic armed_d;
    logic done_q;
    logic done_d;

    // Fires once, the first idle cycle after arming; clear drops an arm
    assign done_d = armed_q && !busy_i && !clear_i;
    assign armed_d = clear_i ? 1'b0 : (arm_i ? 1'b1 : (done_d ? 1'b0 : armed_q));

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            armed_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            armed_q <= armed_d;
            done_q <= done_d;
        end
    end

    assign armed_o = armed_q;
    assign done_o = done_q;

    armed_wait_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        armed_q && busy_i && !clear_i && !arm_i |=> armed_q && !done_q)
        else $error("completion fired while busy");
endmodule
`default_nettype wire

// >>> rtl/std_event_status.sv
// Standard event status register, enable mask, status byte and common queries
//
// Notes on behaviour
// - Clear-status zeroes event latch, operation/questionable events and status byte; masks kept.
// - Clear-status also empties the error queue.
// - Event mask takes 0..255 from controller and resets to zero.
// - Event summary, status bit 5, is set when latch AND mask is nonzero.
// - Latch bits: power-on 7, command 5, execution 4, device 3, query 2, complete 0.
// - Mask query returns the stored mask unchanged, with no side effect.
// - Latch query returns contents and clears them in the same operation.
// - Completion command sets bit 0 once earlier commands and level changes finish.
// - Completion command does not stall later commands.
// - Completion query queues ASCII 1 once pending work is finished.
// - While completion query is outstanding, later commands are held off.
// - Identification returns maker, model, cal date up to 10 chars, serial, firmware.
// - Parser and device errors set the matching latch error bits.
// - Status byte: oper 7, service 6, summary 5, message 4, ques 3, errq 2.
// - Bit 6 set when status byte AND service mask is nonzero; bit 6 not enableable.
// - Serial poll reports and resets request flag; status byte query leaves it.
`timescale 1ns/100ps
`default_nettype none
module std_event_status (
    input wire logic SYS_CLK_I,
    input wire logic RESET_N_I,
    input wire logic CMD_VALID_I,
    input wire logic [3:0] CMD_CODE_I,
    input wire logic [7:0] CMD_ARG_I,
    output logic CMD_READY_O,
    input wire logic BUSY_I,
    input wire logic ERR_CMD_I,
    input wire logic ERR_EXEC_I,
    input wire logic ERR_DEV_I,
    input wire logic ERR_QUERY_I,
    input wire logic OPER_SUM_I,
    input wire logic QUES_SUM_I,
    input wire logic MSG_AVAIL_I,
    input wire logic ERRQ_NONEMPTY_I,
    output logic CLEAR_EVENTS_O,
    output logic REPLY_VALID_O,
    output logic [7:0] REPLY_DATA_O,
    output logic REPLY_CHAR_O,
    output logic IDN_VALID_O,
    output logic [2:0] IDN_FIELD_O,
    output logic [7:0] EVENT_MASK_O,
    output logic [7:0] SERVICE_MASK_O,
    output logic [7:0] STATUS_BYTE_O,
    output logic SRQ_O
);
    typedef enum logic [1:0] {ST_RUN, ST_WAIT_OPC, ST_IDN} state_e;

    state_e state_q;
    state_e state_d;
    logic [7:0] sel_q;
    logic [7:0] sel_d;
    logic [7:0] ese_q;
    logic [7:0] sre_q;
    logic rqs_q;
    logic rqs_d;
    logic [7:0] stb_q;
    logic clr_q;
    logic rv_q;
    logic [7:0] rd_q;
    logic rc_q;
    logic [7:0] rd_d;
    logic rv_d;
    logic rc_d;
    logic iv_q;
    logic [2:0] if_q;
    logic ready_q;

    wire take = CMD_VALID_I && (state_q == ST_RUN);
    wire is_cls = take && CMD_CODE_I == status_pkg::CMD_CLS;
    wire is_ese = take && CMD_CODE_I == status_pkg::CMD_ESE;
    wire is_esr_q = take && CMD_CODE_I == status_pkg::CMD_ESR_Q;
    wire is_opc = take && CMD_CODE_I == status_pkg::CMD_OPC;
    wire is_opc_q = take && CMD_CODE_I == status_pkg::CMD_OPC_Q;
    wire is_idn = take && CMD_CODE_I == status_pkg::CMD_IDN_Q;
    wire is_sre = take && CMD_CODE_I == status_pkg::CMD_SRE;
    wire is_poll = take && CMD_CODE_I == status_pkg::CMD_POLL;

    wire opc_done;
    completion_tracker u_opc (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESET_N_I),
        .arm_i(is_opc),
        .clear_i(is_cls),
        .busy_i(BUSY_I),
        .armed_o(),
        .done_o(opc_done)
    );

    // Fresh events this cycle; they win over a read-and-clear in the same cycle
    wire [7:0] sel_set = ({7'h00, opc_done} << status_pkg::SEL_OPC_BIT)
        | ({7'h00, ERR_CMD_I} << status_pkg::SEL_CME_BIT)
        | ({7'h00, ERR_EXEC_I} << status_pkg::SEL_EXE_BIT)
        | ({7'h00, ERR_DEV_I} << status_pkg::SEL_DDE_BIT)
        | ({7'h00, ERR_QUERY_I} << status_pkg::SEL_QYE_BIT);
    // Sticky latch, cleared only by read-and-clear or clear-status
    assign sel_d = (((is_esr_q || is_cls) ? 8'h00 : sel_q) | sel_set) & status_pkg::SEL_USED_MASK;

    // Next mask, so a mask write reaches the summary on the same edge as a latch change
    wire [7:0] ese_d = is_ese ? CMD_ARG_I : ese_q;
    wire esb = |(sel_d & ese_d);
    wire [7:0] stb_base = ({7'h00, OPER_SUM_I} << status_pkg::STB_OPER_BIT)
        | ({7'h00, esb} << status_pkg::STB_ESB_BIT)
        | ({7'h00, MSG_AVAIL_I} << status_pkg::STB_MAV_BIT)
        | ({7'h00, QUES_SUM_I} << status_pkg::STB_QUES_BIT)
        | ({7'h00, ERRQ_NONEMPTY_I && !is_cls} << status_pkg::STB_ERRQ_BIT);
    // Bit 6 of the service mask is ignored since base bit 6 is always zero
    wire mss = |(stb_base & sre_q);
    wire [7:0] stb_d = is_cls ? 8'h00 : (stb_base | ({7'h00, mss} << status_pkg::STB_MSS_BIT));

    // Request flag rises with a new summary; poll resets it unless a new rise lands
    wire mss_rise = mss && !stb_q[status_pkg::STB_MSS_BIT];
    assign rqs_d = mss_rise || (rqs_q && !is_poll && !is_cls);

    always_comb begin
        rv_d = 1'b0;
        rc_d = 1'b0;
        rd_d = 8'h00;
        if (take && CMD_CODE_I == status_pkg::CMD_ESE_Q) begin
            rv_d = 1'b1;
            rd_d = ese_q;
        end else if (is_esr_q) begin
            rv_d = 1'b1;
            rd_d = sel_q;
        end else if (take && CMD_CODE_I == status_pkg::CMD_SRE_Q) begin
            rv_d = 1'b1;
            rd_d = sre_q;
        end else if (take && CMD_CODE_I == status_pkg::CMD_STB_Q) begin
            rv_d = 1'b1;
            rd_d = stb_q;
        end else if (is_poll) begin
            rv_d = 1'b1;
            rd_d = {stb_q[7], rqs_q, stb_q[5:0]};
        end else if (state_q == ST_WAIT_OPC && !BUSY_I) begin
            rv_d = 1'b1;
            rc_d = 1'b1;
            rd_d = status_pkg::OPC_REPLY_CHAR;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (is_opc_q) begin
                    state_d = ST_WAIT_OPC;
                end else if (is_idn) begin
                    state_d = ST_IDN;
                end
            end
            ST_WAIT_OPC: begin
                if (!BUSY_I) begin
                    state_d = ST_RUN;
                end
            end
            ST_IDN: begin
                if (if_q == status_pkg::IDN_FIRMWARE) begin
                    state_d = ST_RUN;
                end
            end
            default: state_d = ST_RUN;
        endcase
    end

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_q <= ST_RUN;
            sel_q <= status_pkg::SEL_RESET;
            ese_q <= status_pkg::MASK_RESET;
            sre_q <= status_pkg::MASK_RESET;
            rqs_q <= 1'b0;
            stb_q <= 8'h00;
            clr_q <= 1'b0;
            rv_q <= 1'b0;
            rd_q <= 8'h00;
            rc_q <= 1'b0;
            ready_q <= 1'b1;
        end else begin
            state_q <= state_d;
            ready_q <= (state_d == ST_RUN);
            sel_q <= sel_d;
            if (is_ese) begin
                ese_q <= CMD_ARG_I;
            end
            if (is_sre) begin
                sre_q <= CMD_ARG_I & ~(8'h01 << status_pkg::STB_MSS_BIT);
            end
            rqs_q <= rqs_d;
            stb_q <= stb_d;
            clr_q <= is_cls;
            rv_q <= rv_d;
            rd_q <= rd_d;
            rc_q <= rc_d;
        end
    end

    // Identification fields are streamed as selectors; the text lives with the firmware
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            iv_q <= 1'b0;
            if_q <= status_pkg::IDN_MAKER;
        end else if (is_idn) begin
            iv_q <= 1'b1;
            if_q <= status_pkg::IDN_MAKER;
        end else if (state_q == ST_IDN && if_q != status_pkg::IDN_FIRMWARE) begin
            iv_q <= 1'b1;
            if_q <= if_q + 3'h1;
        end else begin
            iv_q <= 1'b0;
            if_q <= status_pkg::IDN_DONE;
        end
    end

    // Held low during the completion query wait and the ident stream; completion command never stalls
    assign CMD_READY_O = ready_q;
    assign CLEAR_EVENTS_O = clr_q;
    assign REPLY_VALID_O = rv_q;
    assign REPLY_DATA_O = rd_q;
    assign REPLY_CHAR_O = rc_q;
    assign IDN_VALID_O = iv_q;
    assign IDN_FIELD_O = if_q;
    assign EVENT_MASK_O = ese_q;
    assign SERVICE_MASK_O = sre_q;
    assign STATUS_BYTE_O = stb_q;
    assign SRQ_O = rqs_q;

    cls_clears_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        is_cls |=> stb_q == 8'h00 && clr_q && $stable(ese_q) && $stable(sre_q))
        else $error("clear-status did not clear status");
    cls_errq_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        is_cls |=> CLEAR_EVENTS_O && !STATUS_BYTE_O[status_pkg::STB_ERRQ_BIT])
        else $error("error queue not cleared");
    mask_write_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        is_ese |=> ese_q == $past(CMD_ARG_I))
        else $error("event mask not stored");
    summary_bit_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        !$past(is_cls) |-> stb_q[status_pkg::STB_ESB_BIT] == |(sel_q & ese_q))
        else $error("event summary wrong");
    unused_zero_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        sel_q[6] == 1'b0 && sel_q[1] == 1'b0)
        else $error("unused latch bit set");
    mask_query_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        take && CMD_CODE_I == status_pkg::CMD_ESE_Q |=> REPLY_VALID_O && REPLY_DATA_O == ese_q)
        else $error("mask query wrong");
    read_clear_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        is_esr_q && sel_set == 8'h00 |=> REPLY_DATA_O == $past(sel_q) && sel_q == 8'h00)
        else $error("latch read did not clear");
    sequence opc_issued_s;
        is_opc ##1 !BUSY_I && !is_cls;
    endsequence
    opc_sets_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        opc_issued_s |=> ##1 sel_q[status_pkg::SEL_OPC_BIT])
        else $error("completion bit not set");
    opc_nostall_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        is_opc |=> CMD_READY_O)
        else $error("completion command stalled");
    opcq_reply_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        state_q == ST_WAIT_OPC && !BUSY_I |=> REPLY_CHAR_O && REPLY_DATA_O == 8'h31)
        else $error("completion reply missing");
    opcq_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        state_q == ST_WAIT_OPC && BUSY_I |=> !CMD_READY_O)
        else $error("commands not held off");
    idn_order_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        is_idn |=> IDN_FIELD_O == 3'h0 ##1 IDN_FIELD_O == 3'h1 ##3 IDN_FIELD_O == 3'h4)
        else $error("ident field order wrong");
    err_sets_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        ERR_CMD_I |=> sel_q[status_pkg::SEL_CME_BIT])
        else $error("command error not latched");
    sticky_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        sel_q[status_pkg::SEL_EXE_BIT] && !is_esr_q && !is_cls |=> sel_q[status_pkg::SEL_EXE_BIT])
        else $error("latch bit lost");
    oper_bit_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        !is_cls |=> STATUS_BYTE_O[status_pkg::STB_OPER_BIT] == $past(OPER_SUM_I) && STATUS_BYTE_O[1:0] == 2'h0)
        else $error("status byte layout wrong");
    mss_bit6_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        is_sre |=> !sre_q[status_pkg::STB_MSS_BIT])
        else $error("bit 6 enabled");
    poll_reset_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        is_poll && !mss_rise |=> !SRQ_O && REPLY_DATA_O[6] == $past(rqs_q))
        else $error("serial poll did not reset flag");
endmodule
`default_nettype wire

// >>> sim/cmd_source_model.sv
// Remote controller model that presents one command at a time and holds it until taken
`timescale 1ns/100ps
`default_nettype none
module cmd_source_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic go_i,
    input wire logic [3:0] code_i,
    input wire logic [7:0] arg_i,
    input wire logic ready_i,
    output logic valid_o,
    output logic [3:0] code_o,
    output logic [7:0] arg_o,
    output logic done_o
);
    // Done blocks a restart while the caller is still dropping its request
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            valid_o <= 1'b0;
            code_o <= 4'h0;
            arg_o <= 8'h00;
            done_o <= 1'b0;
        end else if (valid_o && ready_i) begin
            valid_o <= 1'b0;
            // Released lines show the inverse so stale values are not mistaken for live ones
            code_o <= ~code_o;
            arg_o <= ~arg_o;
            done_o <= 1'b1;
        end else if (go_i && !valid_o && !done_o) begin
            valid_o <= 1'b1;
            code_o <= code_i;
            arg_o <= arg_i;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Testbench for the standard event status block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic go = 1'b0;
    logic [3:0] code = 4'h0;
    logic [7:0] arg = 8'h00;
    logic busy = 1'b0;
    logic [3:0] err = 4'h0;
    logic [3:0] sums = 4'h0;
    logic valid, ready, done, clr, rv, rc, iv, srq;
    logic [3:0] mcode;
    logic [7:0] marg, rdata, emask, smask, stb, last;
    logic [2:0] ifield;
    logic last_char = 1'b0;
    logic saw_clr = 1'b0;
    logic [2:0] idq[$];
    int rep_cnt = 0;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    int k;

    always #5 clk = ~clk;

    cmd_source_model i_cmd_source_model (.clk_i(clk), .rst_n_i(rst_n), .go_i(go), .code_i(code), .arg_i(arg),
        .ready_i(ready), .valid_o(valid), .code_o(mcode), .arg_o(marg), .done_o(done));

    std_event_status i_std_event_status (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .CMD_VALID_I(valid),
        .CMD_CODE_I(mcode), .CMD_ARG_I(marg), .CMD_READY_O(ready), .BUSY_I(busy), .ERR_CMD_I(err[3]),
        .ERR_EXEC_I(err[2]), .ERR_DEV_I(err[1]), .ERR_QUERY_I(err[0]), .OPER_SUM_I(sums[3]),
        .QUES_SUM_I(sums[2]), .MSG_AVAIL_I(sums[1]), .ERRQ_NONEMPTY_I(sums[0]), .CLEAR_EVENTS_O(clr),
        .REPLY_VALID_O(rv), .REPLY_DATA_O(rdata), .REPLY_CHAR_O(rc), .IDN_VALID_O(iv),
        .IDN_FIELD_O(ifield), .EVENT_MASK_O(emask), .SERVICE_MASK_O(smask), .STATUS_BYTE_O(stb),
        .SRQ_O(srq));

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rv === 1'b1) begin
            last <= rdata;
            last_char <= rc;
            rep_cnt <= rep_cnt + 1;
        end
        if (iv === 1'b1)
            idq.push_back(ifield);
        if (clr === 1'b1)
            saw_clr <= 1'b1;
        // Generous ceiling: the whole sequence needs under two hundred cycles
        if (cyc == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            n_mismatch++;
        end
    endtask

    task automatic send(input logic [3:0] c, input logic [7:0] a);
        @(posedge clk);
        go <= 1'b1;
        code <= c;
        arg <= a;
        @(posedge clk);
        while (done !== 1'b1)
            @(posedge clk);
        go <= 1'b0;
    endtask

    task automatic query(input logic [3:0] c, input logic [7:0] a, input string name, input logic [7:0] exp);
        int n0;
        n0 = rep_cnt;
        send(c, a);
        for (int i = 0; i < 20 && rep_cnt == n0; i++)
            @(posedge clk);
        @(negedge clk);
        chk("reply count", 8'h01, 8'(rep_cnt - n0));
        chk(name, exp, last);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk("event mask at reset", 8'h00, emask);
        query(status_pkg::CMD_ESR_Q, 8'h00, "latch after reset", 8'h80);
        query(status_pkg::CMD_ESR_Q, 8'h00, "latch after read", 8'h00);
        @(posedge clk);
        err <= 4'hF;
        @(posedge clk);
        err <= 4'h0;
        wait_cyc(6);
        query(status_pkg::CMD_ESR_Q, 8'h00, "sticky error bits", 8'h3C);
        query(status_pkg::CMD_ESR_Q, 8'h00, "latch cleared by read", 8'h00);
        send(status_pkg::CMD_ESE, 8'hFF);
        for (k = 0; k < 2; k++)
            query(status_pkg::CMD_ESE_Q, 8'h00, "mask query", 8'hFF);
        @(posedge clk);
        sums <= 4'hF;
        wait_cyc(3);
        chk("status byte layout", 8'h9C, stb);
        @(posedge clk);
        sums <= 4'h0;
        send(status_pkg::CMD_ESE, 8'h20);
        @(posedge clk);
        err <= 4'h8;
        @(posedge clk);
        err <= 4'h0;
        wait_cyc(3);
        chk("event summary", 8'h20, stb);
        send(status_pkg::CMD_SRE, 8'h60);
        wait_cyc(3);
        chk("service mask", 8'h20, smask);
        chk("status with request", 8'h60, stb);
        query(status_pkg::CMD_SRE_Q, 8'h00, "service mask query", 8'h20);
        query(status_pkg::CMD_STB_Q, 8'h00, "status query", 8'h60);
        chk("request kept", 8'h01, {7'h00, srq});
        query(status_pkg::CMD_POLL, 8'h00, "serial poll", 8'h60);
        wait_cyc(1);
        chk("request reset by poll", 8'h00, {7'h00, srq});
        send(status_pkg::CMD_CLS, 8'h00);
        wait_cyc(3);
        chk("status after clear", 8'h00, stb);
        chk("event mask kept", 8'h20, emask);
        chk("service mask kept", 8'h20, smask);
        chk("clear pulse", 8'h01, {7'h00, saw_clr});
        query(status_pkg::CMD_ESR_Q, 8'h00, "latch after clear", 8'h00);
        @(posedge clk);
        busy <= 1'b1;
        send(status_pkg::CMD_OPC, 8'h00);
        query(status_pkg::CMD_ESE_Q, 8'h00, "query while pending", 8'h20);
        query(status_pkg::CMD_ESR_Q, 8'h00, "complete bit while busy", 8'h00);
        @(posedge clk);
        busy <= 1'b0;
        wait_cyc(3);
        query(status_pkg::CMD_ESR_Q, 8'h00, "complete bit set", 8'h01);
        @(posedge clk);
        busy <= 1'b1;
        k = rep_cnt;
        send(status_pkg::CMD_OPC_Q, 8'h00);
        wait_cyc(5);
        chk("held off while waiting", 8'h00, {7'h00, ready});
        chk("no early reply", 8'h00, 8'(rep_cnt - k));
        @(posedge clk);
        busy <= 1'b0;
        wait_cyc(4);
        chk("completion reply", status_pkg::OPC_REPLY_CHAR, last);
        chk("reply is character", 8'h01, {7'h00, last_char});
        send(status_pkg::CMD_IDN_Q, 8'h00);
        wait_cyc(8);
        chk("field count", 8'h05, 8'(idq.size()));
        for (k = 0; k < 5 && k < idq.size(); k++)
            chk("field order", 8'(k), {5'h00, idq[k]});
        complete_run();
    end
endmodule
`default_nettype wire
